// *** cdfe_pkg.sv ***
package cdfe_pkg;
  // Register byte offsets on the Avalon bus.
  localparam logic [5:0] REG_CMD0   = 6'h00;
  localparam logic [5:0] REG_CMD1   = 6'h04;
  localparam logic [5:0] REG_CMD2   = 6'h08;
  localparam logic [5:0] REG_CMD3   = 6'h0C;
  localparam logic [5:0] REG_ISSUE  = 6'h10;
  localparam logic [5:0] REG_STATUS = 6'h14;
  localparam logic [5:0] REG_LIMIT  = 6'h18;
  localparam logic [5:0] REG_HEAPSEL = 6'h1C;
  localparam logic [5:0] REG_HEAPLO = 6'h20;
  localparam logic [5:0] REG_HEAPHI = 6'h24;
  localparam logic [5:0] REG_SIPLO  = 6'h28;
  localparam logic [5:0] REG_SIPHI  = 6'h2C;
  // Command opcodes in ISSUE bits 2:0.
  localparam logic [2:0] OP_HEAP   = 3'h1;
  localparam logic [2:0] OP_FRONT  = 3'h2;
  localparam logic [2:0] OP_SIP    = 3'h3;
  localparam logic [2:0] OP_SYNC   = 3'h4;
  localparam logic [2:0] OP_WALK   = 3'h5;
  localparam logic [2:0] OP_POLL   = 3'h6;
  // ISSUE field positions.
  localparam int ISSUE_PFLUSH = 3;
  localparam int ISSUE_LFLUSH = 4;
  localparam int ISSUE_WOP_LO = 5;
  localparam int ISSUE_WAITED = 7;
  // Completion write operations.
  localparam logic [1:0] WOP_NONE = 2'h0;
  localparam logic [1:0] WOP_IMM  = 2'h1;
  localparam logic [1:0] WOP_TS   = 2'h2;
  // Reset values of the thread limits, and the value read from unmapped addresses.
  localparam logic [15:0] MAXTHR_RST = 16'h0040;
  localparam logic [15:0] OVERD_RST  = 16'h0008;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage : cdfe_pkg

// *** cdfe_track_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// Small per-dispatch memory with registered read data.
module cdfe_track_mem #(
  parameter int W = 16,
  parameter int D = 4,
  parameter int AW = 2
) (
  // Clock.
  input  wire logic          ref_clk,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [D];  // Storage words, no reset needed.

  // One write and one registered read each cycle.
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : cdfe_track_mem
`default_nettype wire

// *** cdfe_part_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
// Picks the least loaded compute partition from packed load counts.
module cdfe_part_pick #(
  parameter int PARTS = 4,
  parameter int LW = 8
) (
  // Loads per partition.
  input  wire logic [PARTS*LW-1:0] load,
  // Chosen partition.
  output logic      [1:0]       pick
);
  // Linear scan; lowest index wins ties so the choice is stable.
  always_comb begin
    logic [LW-1:0] best;
    best = load[LW-1:0];
    pick = 2'd0;
    for (int i = 1; i < PARTS; i++) begin
      if (load[i*LW +: LW] < best) begin
        best = load[i*LW +: LW];
        pick = 2'(i);
      end
    end
  end
endmodule : cdfe_part_pick
`default_nettype wire

// *** cdfe_top.sv ***
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Compute dispatch front end: command interpreter behind an Avalon slave.
module cdfe_top
  import cdfe_pkg::*;
#(
  parameter int NPART = 4,
  parameter int LANES = 16
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Avalon-MM slave.
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  // Thread dispatch to partitions.
  output logic                  td_valid,
  output logic      [1:0]       td_part,
  output logic      [1:0]       td_tag,
  output logic      [LANES-1:0] td_mask,
  output logic                  td_last,
  output logic      [63:0]      td_sip,
  input  wire logic             td_ready,
  // Thread exit reports from partitions.
  input  wire logic             tx_valid,
  input  wire logic [1:0]       tx_part,
  input  wire logic [1:0]       tx_tag,
  // Memory side: completion writes and cache flushes.
  output logic                  mw_valid,
  output logic      [63:0]      mw_addr,
  output logic      [127:0]     mw_data,
  output logic      [4:0]       mw_bytes,
  input  wire logic             mw_done,
  output logic                  fl_part,
  output logic                  fl_llc,
  input  wire logic             fl_done,
  input  wire logic             poll_hit
);
  // Command interpreter states.
  typedef enum logic [2:0] {S_IDLE, S_WALK, S_SYNC, S_FLP, S_FLL, S_POLL} cdfe_st_t;

  // All module state.
  typedef struct packed {
    cdfe_st_t             st;
    logic [3:0][31:0]     cmd;       // Command words.
    logic [7:0]           issue;     // Latched issue word.
    logic [3:0][63:0]     heap;      // Heap base addresses.
    logic [1:0]           hsel;
    logic [63:0]          sip;       // Exception handler address.
    logic [15:0]          maxthr;
    logic [15:0]          overd;
    logic [15:0]          active;    // Threads dispatched not yet exited.
    logic [NPART-1:0][7:0] load;     // Per-partition load.
    logic [15:0]          grp_left;  // Threadgroups left in the walker.
    logic [7:0]           thr_left;  // Threads left in the group.
    logic [31:0]          wcfg;      // Group size and last mask, latched at walk start.
    logic [3:0][15:0]     outst;     // Outstanding threads per tag.
    logic [3:0]           fe_done;   // Front end finished per tag.
    logic [3:0]           wr_pend;   // Completion write pending per tag.
    logic [3:0][1:0]      wop;
    logic [3:0][63:0]     waddr;
    logic [3:0][63:0]     wimm;
    logic [3:0]           waited;
    logic [1:0]           tag;       // Next walker tag.
    logic                 be_flush;  // Back end flush in progress.
    logic [1:0]           be_tag;
    logic [31:0]          rdata;
    logic                 wreq_n;
    logic                 td_valid;
    logic [1:0]           td_part;
    logic [LANES-1:0]     td_mask;
    logic                 td_last;
    logic                 mw_valid;
    logic [63:0]          mw_addr;
    logic [127:0]         mw_data;
    logic [4:0]           mw_bytes;
    logic                 fl_part;
    logic                 fl_llc;
    logic [63:0]          tstamp;
  } cdfe_state_t;

  cdfe_state_t s_r;    // Registered state.
  cdfe_state_t s_nxt;  // Next state.
  logic [1:0]  pick;   // Least loaded partition.
  logic [15:0] grp_rd; // Threads-per-group readback, unused beyond tracking.

  cdfe_part_pick #(.PARTS(NPART), .LW(8)) u_pick (
    .load (s_r.load),
    .pick (pick)
  );

  // Mirror of per-tag group size so a reader can check allocation; registered read.
  cdfe_track_mem #(.W(16), .D(4), .AW(2)) u_mem (
    .ref_clk (ref_clk),
    .we      (s_r.st == S_IDLE && s_nxt.st == S_WALK),
    .waddr   (s_r.tag),
    .wdata   (s_r.cmd[1][15:0]),
    .raddr   (s_r.be_tag),
    .rdata   (grp_rd)
  );

  // True when no tag has threads outstanding; a simple helper.
  function automatic logic all_idle(input logic [3:0][15:0] o);
    return (o[0] == 16'h0000) && (o[1] == 16'h0000) && (o[2] == 16'h0000) && (o[3] == 16'h0000);
  endfunction : all_idle

  // Next state: bus slave, interpreter, dispatch, exit tracking, back end.
  always_comb begin
    logic go;
    logic [7:0] iw;
    logic [15:0] inc;
    logic [15:0] dec;
    logic [1:0] dst;
    go  = 1'b0;
    iw  = s_r.issue;
    inc = 16'h0000;
    dec = 16'h0000;
    dst = (s_r.thr_left == s_r.wcfg[7:0]) ? pick : s_r.td_part;  // A group stays on one partition.
    s_nxt = s_r;
    s_nxt.tstamp = s_r.tstamp + 64'h0000_0000_0000_0001;
    s_nxt.td_valid = s_r.td_valid & ~td_ready;
    s_nxt.wreq_n = 1'b1;
    // Bus: one cycle of waitrequest low per access, issued writes stall while busy.
    if ((avs_read || avs_write) && s_r.wreq_n) begin
      if (avs_write) begin
        if (avs_address == REG_ISSUE) begin
          if (s_r.st == S_IDLE) begin
            s_nxt.wreq_n = 1'b0;
            s_nxt.issue  = avs_writedata[7:0];
            iw  = avs_writedata[7:0];
            go  = 1'b1;
          end
        end else begin
          s_nxt.wreq_n = 1'b0;
          if (avs_address == REG_CMD0) s_nxt.cmd[0] = avs_writedata;
          else if (avs_address == REG_CMD1) s_nxt.cmd[1] = avs_writedata;
          else if (avs_address == REG_CMD2) s_nxt.cmd[2] = avs_writedata;
          else if (avs_address == REG_CMD3) s_nxt.cmd[3] = avs_writedata;
          else if (avs_address == REG_HEAPSEL) s_nxt.hsel = avs_writedata[1:0];
        end
      end else begin
        s_nxt.wreq_n = 1'b0;
        if (avs_address == REG_STATUS) begin
          s_nxt.rdata = {13'h0000, s_r.st, s_r.fe_done, s_r.wr_pend, s_r.active[7:0]};
        end else if (avs_address == REG_LIMIT) s_nxt.rdata = {s_r.overd, s_r.maxthr};
        else if (avs_address == REG_HEAPLO) s_nxt.rdata = s_r.heap[s_r.hsel][31:0];
        else if (avs_address == REG_HEAPHI) s_nxt.rdata = s_r.heap[s_r.hsel][63:32];
        else if (avs_address == REG_SIPLO) s_nxt.rdata = s_r.sip[31:0];
        else if (avs_address == REG_SIPHI) s_nxt.rdata = s_r.sip[63:32];
        else s_nxt.rdata = UNMAPPED_RD;
      end
    end
    // Command start.
    if (go) begin
      case (iw[2:0])
        OP_HEAP:  s_nxt.heap[s_r.cmd[2][1:0]] = {s_r.cmd[1], s_r.cmd[0]};
        OP_FRONT: begin
          s_nxt.maxthr = s_r.cmd[0][15:0];
          s_nxt.overd  = s_r.cmd[0][31:16];
        end
        OP_SIP:   s_nxt.sip = {s_r.cmd[1], s_r.cmd[0]};
        OP_SYNC:  s_nxt.st = S_SYNC;
        OP_POLL:  s_nxt.st = S_POLL;
        OP_WALK: begin
          // Walker: cmd0 = X/Y/Z counts cmd1 = threads per group and last mask
          // cmd2/cmd3 = completion address; immediate data is the same cmd3:cmd2 pair.
          if (!s_r.fe_done[s_r.tag] || s_r.wr_pend[s_r.tag] || s_r.outst[s_r.tag] != 16'h0000) begin
            s_nxt.st = S_IDLE;  // Tag still busy; the producer re-issues.
          end else begin
            s_nxt.st = S_WALK;
            s_nxt.grp_left = 16'((s_r.cmd[0][9:0] + 10'd0) * (s_r.cmd[0][19:10] + 10'd0)
                             * (s_r.cmd[0][29:20] + 10'd0));
            s_nxt.thr_left = s_r.cmd[1][7:0];
            s_nxt.wcfg = s_r.cmd[1];  // Later command writes cannot disturb this walk.
            s_nxt.fe_done[s_r.tag] = 1'b0;
            s_nxt.wop[s_r.tag] = iw[ISSUE_WOP_LO +: 2];
            s_nxt.waited[s_r.tag] = iw[ISSUE_WAITED];
            s_nxt.waddr[s_r.tag] = {s_r.cmd[3], s_r.cmd[2]};
            s_nxt.wimm[s_r.tag] = {s_r.cmd[3], s_r.cmd[2]};
          end
        end
        default: s_nxt.st = S_IDLE;
      endcase
    end
    // Interpreter waits.
    case (s_r.st)
      S_WALK: begin
        // Dispatch while under both thread limits, oldest walker only.
        if ((!s_r.td_valid || td_ready) && s_r.grp_left != 16'h0000
            && s_r.active < s_r.maxthr
            && s_r.load[dst] < s_r.overd[7:0]) begin
          s_nxt.td_valid = 1'b1;
          s_nxt.td_part  = dst;
          s_nxt.td_last  = (s_r.thr_left == 8'h01);
          s_nxt.td_mask  = (s_r.thr_left == 8'h01) ? s_r.wcfg[8 +: LANES] : '1;
          inc = 16'h0001;
          s_nxt.outst[s_r.tag] = s_r.outst[s_r.tag] + 16'h0001;
          s_nxt.load[dst] = s_r.load[dst] + 8'h01;
          if (s_r.thr_left == 8'h01) begin
            s_nxt.thr_left = s_r.wcfg[7:0];
            s_nxt.grp_left = s_r.grp_left - 16'h0001;
          end else begin
            s_nxt.thr_left = s_r.thr_left - 8'h01;
          end
        end else if (s_r.grp_left == 16'h0000 && !s_r.td_valid) begin
          s_nxt.fe_done[s_r.tag] = 1'b1;
          s_nxt.wr_pend[s_r.tag] = (s_r.wop[s_r.tag] != WOP_NONE);
          s_nxt.tag = s_r.tag + 2'd1;
          s_nxt.st  = S_IDLE;
        end
      end
      S_SYNC: if (s_r.active == 16'h0000 && all_idle(s_r.outst) && s_r.wr_pend == 4'h0) begin
        s_nxt.st = s_r.issue[ISSUE_PFLUSH] ? S_FLP : (s_r.issue[ISSUE_LFLUSH] ? S_FLL : S_IDLE);
      end
      S_FLP: begin
        s_nxt.fl_part = 1'b1;
        if (fl_done && s_r.fl_part) begin
          s_nxt.fl_part = 1'b0;
          s_nxt.st = s_r.issue[ISSUE_LFLUSH] ? S_FLL : S_IDLE;
        end
      end
      S_FLL: begin
        s_nxt.fl_llc = 1'b1;
        if (fl_done && s_r.fl_llc) begin
          s_nxt.fl_llc = 1'b0;
          s_nxt.st = S_IDLE;
        end
      end
      S_POLL: if (poll_hit) s_nxt.st = S_IDLE;
      default: ;
    endcase
    // Thread exits free slots and decrement counts.
    if (tx_valid) begin
      dec = 16'h0001;
      s_nxt.outst[tx_tag] = s_nxt.outst[tx_tag] - 16'h0001;
      s_nxt.load[tx_part] = s_nxt.load[tx_part] - 8'h01;
    end
    s_nxt.active = s_r.active + inc - dec;
    // Back end: completion write once front end done and count zero.
    if (!s_r.mw_valid && !s_r.be_flush) begin
      for (int t = 0; t < 4; t++) begin
        if (s_r.fe_done[t] && s_r.wr_pend[t] && s_r.outst[t] == 16'h0000
            && !s_nxt.mw_valid && !s_nxt.be_flush && s_r.st != S_FLP) begin
          s_nxt.be_tag = 2'(t);
          if (s_r.waited[t]) begin
            s_nxt.be_flush = 1'b1;
          end else begin
            s_nxt.mw_valid = 1'b1;
          end
        end
      end
    end
    if (s_r.be_flush) begin
      s_nxt.fl_part = 1'b1;
      if (fl_done && s_r.fl_part) begin
        s_nxt.fl_part  = 1'b0;
        s_nxt.be_flush = 1'b0;
        s_nxt.mw_valid = 1'b1;
      end
    end
    if (s_nxt.mw_valid && !s_r.mw_valid) begin
      if (s_r.wop[s_nxt.be_tag] == WOP_TS) begin
        s_nxt.mw_addr  = {s_r.waddr[s_nxt.be_tag][63:4], 4'h0};
        s_nxt.mw_data  = {64'h0000_0000_0000_0000, s_r.tstamp};
        s_nxt.mw_bytes = 5'd16;
      end else begin
        s_nxt.mw_addr  = {s_r.waddr[s_nxt.be_tag][63:3], 3'h0};
        s_nxt.mw_data  = {64'h0000_0000_0000_0000, s_r.wimm[s_nxt.be_tag]};
        s_nxt.mw_bytes = 5'd8;
      end
    end
    if (s_r.mw_valid && mw_done) begin
      s_nxt.mw_valid = 1'b0;
      s_nxt.wr_pend[s_r.be_tag] = 1'b0;
    end
  end

  // Single state register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r        <= '0;
      s_r.st     <= S_IDLE;
      s_r.maxthr <= MAXTHR_RST;
      s_r.overd  <= OVERD_RST;
      s_r.fe_done <= 4'hF;
      s_r.wreq_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state flip-flops.
  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.wreq_n;
  assign td_valid = s_r.td_valid;
  assign td_part  = s_r.td_part;
  assign td_tag   = s_r.tag;
  assign td_mask  = s_r.td_mask;
  assign td_last  = s_r.td_last;
  assign td_sip   = s_r.sip;
  assign mw_valid = s_r.mw_valid;
  assign mw_addr  = s_r.mw_addr;
  assign mw_data  = s_r.mw_data;
  assign mw_bytes = s_r.mw_bytes;
  assign fl_part  = s_r.fl_part;
  assign fl_llc   = s_r.fl_llc;

  chk_active_cap: assert property (@(posedge ref_clk) disable iff (rst)
    s_r.active <= s_r.maxthr || $past(s_r.active) > s_r.active || s_r.active == $past(s_r.active))
    else $error("active threads rose above cap");
  chk_mask_full: assert property (@(posedge ref_clk) disable iff (rst)
    (td_valid && !td_last) |-> td_mask == {LANES{1'b1}})
    else $error("non-last thread without full mask");
  chk_imm_align: assert property (@(posedge ref_clk) disable iff (rst)
    (mw_valid && mw_bytes == 5'd8) |-> mw_addr[2:0] == 3'h0)
    else $error("immediate write misaligned");
  chk_ts_align: assert property (@(posedge ref_clk) disable iff (rst)
    (mw_valid && mw_bytes == 5'd16) |-> mw_addr[3:0] == 4'h0)
    else $error("timestamp write misaligned");
  chk_write_after: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(mw_valid) |-> s_r.outst[s_r.be_tag] == 16'h0000)
    else $error("completion write before threads done");
  chk_sync_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.st == S_SYNC && s_r.active != 16'h0000) |=> s_r.st == S_SYNC)
    else $error("sync left with threads active");
  chk_flush_first: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(mw_valid) && s_r.waited[s_r.be_tag]) |-> $past(fl_part))
    else $error("waited write without prior flush");
  chk_pick_least: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(td_valid) |-> $past(s_r.load[pick]) <= $past(s_r.load[0]))
    else $error("dispatch not to least loaded");
endmodule : cdfe_top
`default_nettype wire

// *** cdfe_part_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural compute partitions, execution units and memory beside the front end.
module cdfe_part_model (
  // Clock, reset and random source.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] rnd,
  // Thread dispatch and exit.
  input  wire logic        td_valid,
  input  wire logic [1:0]  td_part,
  input  wire logic [1:0]  td_tag,
  output logic             td_ready,
  output logic             tx_valid,
  output logic      [1:0]  tx_part,
  output logic      [1:0]  tx_tag,
  // Memory writes, flushes and polling.
  input  wire logic        mw_valid,
  output logic             mw_done,
  input  wire logic        fl_part,
  input  wire logic        fl_llc,
  output logic             fl_done,
  output logic             poll_hit,
  // Observation for the bench.
  output logic      [7:0]  outst,
  output logic             pick_ok
);
  logic [7:0] load [4];  // Resident threads per partition.
  logic [7:0] view [4];  // Loads as the dispatcher saw them when it chose.
  logic       ev   [32]; // Thread slot in use.
  logic [1:0] ep   [32]; // Partition of the slot.
  logic [1:0] et   [32]; // Walker tag of the slot.
  logic [5:0] ec   [32]; // Cycles left before the thread exits.
  logic [5:0] mc;        // Cycles a memory write has waited.
  logic [5:0] fc;        // Cycles a flush has waited.
  int         fi;        // First free slot.
  int         xi;        // First slot due to exit.
  // Random stalls make the dispatcher hold its request; a nearly full model refuses.
  assign td_ready = (rnd[0] | rnd[1]) && (outst < 8'h1E);
  assign outst    = load[0] + load[1] + load[2] + load[3];
  // A group may only land on a partition no busier than any other.
  assign pick_ok  = (view[td_part] <= view[0]) && (view[td_part] <= view[1])
                 && (view[td_part] <= view[2]) && (view[td_part] <= view[3]);
  // Threads run for a random time, then report their exit and free the slot.
  always @(posedge ref_clk) begin
    fi = -1;
    xi = -1;
    for (int i = 0; i < 32; i++) begin
      if (rst) ev[i] <= 1'b0;
      if (ev[i] && ec[i] != 6'h0) ec[i] <= ec[i] - 6'h1;
      if (ev[i] && ec[i] == 6'h0 && xi < 0) xi = i;
      if (!ev[i] && fi < 0) fi = i;
    end
    for (int p = 0; p < 4; p++)
      load[p] <= rst ? 8'h0 : load[p] + 8'(td_valid && td_ready && td_part == p)
                 - 8'(tx_valid && tx_part == p);
    // A fresh offer is judged on the loads held at its choice, pending thread included.
    if (!td_valid || td_ready)
      for (int p = 0; p < 4; p++) view[p] <= load[p] + 8'(td_valid && td_part == p);
    if (!rst && xi >= 0) ev[xi] <= 1'b0;
    if (!rst && td_valid && td_ready) begin
      ev[fi] <= 1'b1;
      ep[fi] <= td_part;
      et[fi] <= td_tag;
      ec[fi] <= {1'b0, rnd[8:4]};
    end
    // Idle exit lines show the inverse of their last value.
    tx_valid <= !rst && xi >= 0;
    tx_part  <= rst ? 2'h0 : (xi >= 0) ? ep[xi] : ~tx_part;
    tx_tag   <= rst ? 2'h0 : (xi >= 0) ? et[xi] : ~tx_tag;
    mc       <= (mw_valid && !mw_done) ? mc + 6'h1 : 6'h0;
    mw_done  <= !rst && mw_valid && !mw_done && mc >= {2'h0, rnd[11:8]};
    fc       <= ((fl_part || fl_llc) && !fl_done) ? fc + 6'h1 : 6'h0;
    fl_done  <= !rst && (fl_part || fl_llc) && !fl_done && fc >= {2'h0, rnd[15:12]};
    // New work re-arms the polled location; a landed write marks it changed.
    poll_hit <= rst ? 1'b0 : mw_done ? 1'b1 : (td_valid && td_ready) ? 1'b0 : poll_hit;
  end
endmodule : cdfe_part_model
`default_nettype wire

// *** compute_dispatch_front_end_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the compute dispatch front end.
module compute_dispatch_front_end_tb;
  import cdfe_pkg::*;
  // Notes of expected thread dispatches and completion writes.
  typedef struct {logic [15:0] mask; logic last; logic [31:0] addr;} cdfe_tdn_t;
  typedef struct {logic [31:0] addr; logic [31:0] data; logic ts; logic waited;} cdfe_mwn_t;
  logic         ref_clk, rst, avs_read, avs_write, avs_waitrequest, td_valid, td_ready;
  logic         td_last, tx_valid, mw_valid, mw_done, fl_part, fl_llc, fl_done, poll_hit;
  logic         pick_ok, mw_prev, fl_prev, grp1, pf_seen;
  logic [1:0]   td_part, td_tag, tx_part, tx_tag, gp;
  logic [4:0]   mw_bytes;
  logic [5:0]   avs_address;
  logic [7:0]   outst;
  logic [15:0]  td_mask, rnd;
  logic [31:0]  avs_writedata, avs_readdata, rq, sip_lo, sip_hi, lo, hi, tag_addr [4];
  logic [63:0]  td_sip, mw_addr;
  logic [127:0] mw_data;
  int           bad_count, compares, maxthr, tcnt [4];
  cdfe_tdn_t    tdq [$];
  cdfe_mwn_t    mwq [$];
  cdfe_top #(.NPART(4), .LANES(16)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .td_valid(td_valid), .td_part(td_part),
    .td_tag(td_tag), .td_mask(td_mask), .td_last(td_last), .td_sip(td_sip),
    .td_ready(td_ready), .tx_valid(tx_valid), .tx_part(tx_part), .tx_tag(tx_tag),
    .mw_valid(mw_valid), .mw_addr(mw_addr), .mw_data(mw_data), .mw_bytes(mw_bytes),
    .mw_done(mw_done), .fl_part(fl_part), .fl_llc(fl_llc), .fl_done(fl_done),
    .poll_hit(poll_hit));
  cdfe_part_model u_part (.ref_clk(ref_clk), .rst(rst), .rnd(rnd), .td_valid(td_valid),
    .td_part(td_part), .td_tag(td_tag), .td_ready(td_ready), .tx_valid(tx_valid),
    .tx_part(tx_part), .tx_tag(tx_tag), .mw_valid(mw_valid), .mw_done(mw_done),
    .fl_part(fl_part), .fl_llc(fl_llc), .fl_done(fl_done), .poll_hit(poll_hit),
    .outst(outst), .pick_ok(pick_ok));
  // Clock of 25 ns.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // The random source steps once a cycle and feeds the partner's timing.
  always @(posedge ref_clk) rnd <= lfsr(rnd);
  task automatic give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_td(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t dispatch %h expected %h", $time, got, exp);
    end
  endtask : chk_td
  task automatic chk_flag(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t condition failed", $time);
    end
  endtask : chk_flag
  // One bus transfer; the request stands until waitrequest is sampled low.
  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 5000);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 5000) begin
      bad_count++;
      give_verdict();
    end
  endtask : av
  task automatic issue(input logic [31:0] c0, c1, c2, c3, input logic [7:0] op);
    av(1'b1, REG_CMD0, c0);
    av(1'b1, REG_CMD1, c1);
    av(1'b1, REG_CMD2, c2);
    av(1'b1, REG_CMD3, c3);
    av(1'b1, REG_ISSUE, {24'h00_0000, op});
  endtask : issue
  // Notes every thread of a walk, then its completion write if it has one, then issues it.
  task automatic walk(input int x, y, tpg, input logic [15:0] lm, input logic [1:0] wop,
                      input logic wt, input logic [31:0] adr);
    logic [31:0] dat;
    dat = {rnd, rnd} | 32'h0000_0001;
    for (int g = 0; g < x * y * tpg; g++)
      tdq.push_back('{(g % tpg == tpg - 1) ? lm : 16'hFFFF, g % tpg == tpg - 1, adr});
    if (wop != WOP_NONE) mwq.push_back('{adr, dat, wop == WOP_TS, wt});
    issue({12'h001, 10'(y), 10'(x)}, {8'h00, lm, 8'(tpg)}, adr, dat, {wt, wop, 2'b00, OP_WALK});
  endtask : walk
  // Watches the outputs; takes the oldest dispatch note and the newest fitting write note off the queues.
  always @(posedge ref_clk) begin : mon
    int        k;
    cdfe_tdn_t n;
    if (rst) begin
      grp1    = 1'b1;
      pf_seen = 1'b0;
      mw_prev = 1'b0;
      fl_prev = 1'b0;
      for (int t = 0; t < 4; t++) tcnt[t] = 0;
    end else begin
      if (tx_valid) tcnt[tx_tag]--;
      if (td_valid && td_ready) begin
        chk_flag(tdq.size() != 0);
        if (tdq.size() != 0) n = tdq.pop_front();
        chk_td({47'h0, td_last, td_mask}, {47'h0, n.last, n.mask});
        chk_td(td_sip, {sip_hi, sip_lo});
        if (grp1) chk_flag(pick_ok);
        else chk_flag(td_part === gp);
        gp = td_part;
        pf_seen = 1'b0;
        chk_flag(outst < maxthr);
        grp1 = td_last;
        tcnt[td_tag]++;
        tag_addr[td_tag] = n.addr;
      end
      if (mw_valid && !mw_prev) begin
        k = -1;
        foreach (mwq[i]) if (mwq[i].addr === mw_addr[31:0]) k = i;
        chk_flag(k >= 0);
        if (k >= 0) begin
          chk_reg({27'h0, mw_bytes}, mwq[k].ts ? 32'h0000_0010 : 32'h0000_0008);
          if (!mwq[k].ts) chk_reg(mw_data[31:0], mwq[k].addr);
          if (!mwq[k].ts) chk_reg(mw_data[63:32], mwq[k].data);
          if (mwq[k].waited) chk_flag(pf_seen);
          foreach (tdq[i]) chk_flag(tdq[i].addr !== mwq[k].addr);
          for (int t = 0; t < 4; t++)
            if (tag_addr[t] === mwq[k].addr) chk_flag(tcnt[t] == 0);
          mwq.delete(k);
        end
        pf_seen = 1'b0;
      end
      if ((fl_part || fl_llc) && !fl_prev) chk_flag(outst == 8'h00);
      if (fl_part && fl_done) pf_seen = 1'b1;
      mw_prev = mw_valid;
      fl_prev = fl_part || fl_llc;
    end
  end
  // Main sequence: state, back-to-back walks, sync with flushes, waited walk and poll.
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    rnd = 16'h31FB;
    bad_count = 0;
    compares = 0;
    maxthr = int'(MAXTHR_RST);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    av(1'b0, REG_LIMIT, 32'h0000_0000);
    chk_reg(rq, {OVERD_RST, MAXTHR_RST});
    av(1'b0, 6'h30, 32'h0000_0000);
    chk_reg(rq, UNMAPPED_RD);
    // State at the start of a submission needs no sync ahead of it.
    for (int i = 0; i < 4; i++) begin
      lo = {rnd, rnd ^ 16'h5A5A};
      hi = {rnd ^ 16'hA5A5, rnd};
      issue(lo, hi, i, 32'h0000_0000, {5'h00, OP_HEAP});
      av(1'b1, REG_HEAPSEL, i);
      av(1'b0, REG_HEAPLO, 32'h0000_0000);
      chk_reg(rq, lo);
      av(1'b0, REG_HEAPHI, 32'h0000_0000);
      chk_reg(rq, hi);
    end
    sip_lo = {rnd, 16'h0100};
    sip_hi = {16'h0000, rnd};
    issue(sip_lo, sip_hi, 32'h0000_0000, 32'h0000_0000, {5'h00, OP_SIP});
    av(1'b0, REG_SIPHI, 32'h0000_0000);
    chk_reg(rq, sip_hi);
    maxthr = 6;
    issue(32'h0002_0006, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, {5'h00, OP_FRONT});
    av(1'b0, REG_LIMIT, 32'h0000_0000);
    chk_reg(rq, 32'h0002_0006);
    for (int w = 0; w < 4; w++)
      walk(1 + rnd[1:0] % 3, 1 + rnd[2], 1 + rnd[5:4], 16'h0003 << (4 * w), 2'(w % 3), 1'b0,
           32'h1000_0000 + 32'(w) * 32'h0000_0010);
    issue(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, {3'h0, 2'b11, OP_SYNC});
    issue(sip_lo, sip_hi, 32'h0000_0000, 32'h0000_0000, {5'h00, OP_SIP});
    chk_flag(outst == 8'h00);
    walk(2, 1, 3, 16'h8001, WOP_IMM, 1'b1, 32'h2000_0000);
    av(1'b1, REG_ISSUE, {29'h0, OP_POLL});
    av(1'b1, REG_ISSUE, {29'h0, OP_SYNC});
    chk_flag(mwq.size() == 0);
    av(1'b0, REG_STATUS, 32'h0000_0000);
    chk_reg(rq, 32'h0000_F000);
    for (int n = 0; n < 2000 && (tdq.size() != 0 || outst != 8'h00); n++) @(posedge ref_clk);
    chk_flag(tdq.size() == 0 && mwq.size() == 0);
    give_verdict();
  end
endmodule : compute_dispatch_front_end_tb
`default_nettype wire
